// file: shared/rsac_cfg.svh
// Constants of the resource sleep/active control block
// Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus
`ifndef RSAC_CFG_SVH
`define RSAC_CFG_SVH

// ----------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------
`define NUM_RES         8
`define RES_IDX_W       3
`define CLK_PERIOD_NS   10
`define SEQ_STEP_NS     1000
`define SEQ_STEP_CYC    ((`SEQ_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEQ_CNT_W       16

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADR_W           8
`define OFF_CTRL        8'h00
`define OFF_ASSIGN_SLP  8'h04
`define OFF_ASSIGN_A    8'h08
`define OFF_ASSIGN_B    8'h0C
`define OFF_STATUS      8'h10

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CTRL_MASK_BIT   0
`define CTRL_MASK_RST   1'b1
`define ASSIGN_RST      8'h00
`define MODE_RST        8'hFF
`define ST_MODE_LSB     0
`define ST_STATE_LSB    16
`define ST_PIN_SLP_BIT  24
`define ST_PIN_A_BIT    25
`define ST_PIN_B_BIT    26

`endif

// file: shared/rsac_pkg.sv
// Types of the resource sleep/active control block
// Assumes rsac_cfg.svh is on the include path
package rsac_pkg;
  `include "rsac_cfg.svh"

  typedef logic [`NUM_RES-1:0] res_vec_t;

  typedef enum logic [1:0] {
    SEQ_AWAKE     = 2'b00,
    SEQ_TO_SLEEP  = 2'b01,
    SEQ_ASLEEP    = 2'b10,
    SEQ_TO_ACTIVE = 2'b11
  } seq_state_t;

  typedef enum logic [2:0] {
    REG_NONE       = 3'b000,
    REG_CTRL       = 3'b001,
    REG_ASSIGN_SLP = 3'b010,
    REG_ASSIGN_A   = 3'b011,
    REG_ASSIGN_B   = 3'b100,
    REG_STATUS     = 3'b101
  } reg_sel_t;
endpackage

// file: shared/seq_if.sv
// Link between the register block and the sleep sequencer
// Assumes both ends run on the same clock
`timescale 1ns/1ns
interface seq_if;
  import rsac_pkg::*;

  res_vec_t   awake;
  seq_state_t state;
  logic       sleep_req;
  logic       hold;

  modport ctrl (output sleep_req, hold, input awake, state);
  modport seq  (input sleep_req, hold, output awake, state);
endinterface

// file: core/sleep_sequencer.sv
// Power sequence controller for resources tied to the sleep request
// Assumes synchronous active-high reset and the seq_if link
`timescale 1ns/1ns
`include "rsac_cfg.svh"
module sleep_sequencer
  import rsac_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  seq_if.seq        sq
);

  seq_state_t              state_reg;
  logic [`RES_IDX_W-1:0]   idx_reg;
  logic [`SEQ_CNT_W-1:0]   cnt_reg;
  res_vec_t                awake_reg;
  logic                    step_done;

  localparam logic [`SEQ_CNT_W-1:0] STEP_LAST = `SEQ_CNT_W'(`SEQ_STEP_CYC - 1);
  localparam logic [`RES_IDX_W-1:0] IDX_LAST  = `RES_IDX_W'(`NUM_RES - 1);

  assign step_done = (cnt_reg == STEP_LAST);
  assign sq.state  = state_reg;
  assign sq.awake  = awake_reg;

  // ----------------------------------------------------------------------
  // Sequence state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SEQ_AWAKE;
      idx_reg   <= '0;
    end else begin
      case (state_reg)
        SEQ_AWAKE: begin
          if (!sq.hold && sq.sleep_req) begin // [R1] [R7]
            state_reg <= SEQ_TO_SLEEP;
            idx_reg   <= '0;
          end
        end
        SEQ_TO_SLEEP: begin
          if (step_done) begin
            if (idx_reg == IDX_LAST) state_reg <= SEQ_ASLEEP;
            else idx_reg <= idx_reg + 1'b1;
          end
        end
        SEQ_ASLEEP: begin
          if (!sq.hold && !sq.sleep_req) begin // [R1] [R7]
            state_reg <= SEQ_TO_ACTIVE;
            idx_reg   <= IDX_LAST;
          end
        end
        SEQ_TO_ACTIVE: begin
          if (step_done) begin
            if (idx_reg == '0) state_reg <= SEQ_AWAKE;
            else idx_reg <= idx_reg - 1'b1;
          end
        end
        default: state_reg <= SEQ_AWAKE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Step timer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if ((state_reg == SEQ_TO_SLEEP) || (state_reg == SEQ_TO_ACTIVE)) begin
      cnt_reg <= step_done ? '0 : cnt_reg + 1'b1;
    end else begin
      cnt_reg <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Sequenced resource modes, one resource per step
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awake_reg <= `MODE_RST;
    end else if (step_done && (state_reg == SEQ_TO_SLEEP)) begin
      awake_reg[idx_reg] <= 1'b0; // [R2]
    end else if (step_done && (state_reg == SEQ_TO_ACTIVE)) begin
      awake_reg[idx_reg] <= 1'b1; // [R2]
    end
  end

endmodule // sleep_sequencer

// file: core/resource_mode_mux.sv
// Per-resource mode selection from the three pin assignments
// Assumes the sequenced modes come from sleep_sequencer
`timescale 1ns/1ns
`include "rsac_cfg.svh"
module resource_mode_mux
  import rsac_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire res_vec_t assign_slp_i,
  input  wire res_vec_t assign_a_i,
  input  wire res_vec_t assign_b_i,
  input  wire logic     pin_a_i,
  input  wire logic     pin_b_i,
  input  wire res_vec_t seq_awake_i,
  output res_vec_t      mode_o
);

  res_vec_t mode_reg;

  assign mode_o = mode_reg;

  // ----------------------------------------------------------------------
  // One mode flop per resource; 1 is ACTIVE, 0 is SLEEP
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < `NUM_RES; i++) begin : g_res
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mode_reg[i] <= 1'b1;
      end else if (!(assign_slp_i[i] | assign_a_i[i] | assign_b_i[i])) begin
        mode_reg[i] <= 1'b1; // [R6]
      end else begin
        mode_reg[i] <= (assign_a_i[i] & pin_a_i)          // [R3] [R4]
                     | (assign_b_i[i] & pin_b_i)          // [R3] [R4]
                     | (assign_slp_i[i] & seq_awake_i[i]); // [R2]
      end
    end
  end

endmodule // resource_mode_mux

// file: core/resource_sleep_active_control.sv
// Resource sleep/active control: registers, sequencer and mode selection
// Assumes a classic Wishbone master and pins synchronous to clk_i
//
// What this block does
// [R1] Sleep pin is an active-low level request, maskable, mask set after reset.
// [R2] Sleep-pin resources change mode through the sequenced sleep or wake steps.
// [R3] Any resource can be tied to either direct pin and follow it.
// [R4] A direct pin change switches its resources at once, ignoring the sequencer.
// [R5] Each resource has assignment bits for sleep pin, pin a and pin b.
// [R6] A resource tied to no pin stays ACTIVE whatever the pins do.
// [R7] While masked, the sleep pin starts no sequence; a sequence already running still runs to its end.
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "rsac_cfg.svh"
module resource_sleep_active_control
  import rsac_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [`ADR_W-1:0] adr_i,
  input  wire logic [31:0]       dat_i,
  input  wire logic [3:0]        sel_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  input  wire logic              sleep_request_pin_n_i,
  input  wire logic              direct_mode_pin_a_i,
  input  wire logic              direct_mode_pin_b_i,
  output res_vec_t               resource_mode_o,
  output logic                   seq_busy_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        mask_reg;
  res_vec_t    assign_slp_reg;
  res_vec_t    assign_a_reg;
  res_vec_t    assign_b_reg;
  res_vec_t    mode_w;
  logic        wr_en;
  logic        rd_en;
  reg_sel_t    wr_sel;
  reg_sel_t    rd_sel;

  seq_if sq ();

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic reg_sel_t decode_reg(input logic [`ADR_W-1:0] adr);
    case (adr)
      `OFF_CTRL:       decode_reg = REG_CTRL;
      `OFF_ASSIGN_SLP: decode_reg = REG_ASSIGN_SLP;
      `OFF_ASSIGN_A:   decode_reg = REG_ASSIGN_A;
      `OFF_ASSIGN_B:   decode_reg = REG_ASSIGN_B;
      `OFF_STATUS:     decode_reg = REG_STATUS;
      default:         decode_reg = REG_NONE;
    endcase
  endfunction

  assign wr_sel = decode_reg(adr_i);
  assign rd_sel = decode_reg(adr_i);

  // ----------------------------------------------------------------------
  // Wishbone handshake
  // ----------------------------------------------------------------------
  // Ack rises one cycle after the request and drops the cycle after.
  // Writes land on the edge at which the master samples ack.
  assign wr_en = cyc_i & stb_i & we_i & ack_reg;
  assign rd_en = cyc_i & stb_i & ~we_i & ~ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
    end
  end

  assign ack_o = ack_reg;

  // ----------------------------------------------------------------------
  // Control register: sleep request mask
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= `CTRL_MASK_RST; // [R1]
    end else if (wr_en && (wr_sel == REG_CTRL) && sel_i[0]) begin
      mask_reg <= dat_i[`CTRL_MASK_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Assignment registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      assign_slp_reg <= `ASSIGN_RST;
    end else if (wr_en && (wr_sel == REG_ASSIGN_SLP) && sel_i[0]) begin
      assign_slp_reg <= dat_i[`NUM_RES-1:0]; // [R5]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      assign_a_reg <= `ASSIGN_RST;
    end else if (wr_en && (wr_sel == REG_ASSIGN_A) && sel_i[0]) begin
      assign_a_reg <= dat_i[`NUM_RES-1:0]; // [R5]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      assign_b_reg <= `ASSIGN_RST;
    end else if (wr_en && (wr_sel == REG_ASSIGN_B) && sel_i[0]) begin
      assign_b_reg <= dat_i[`NUM_RES-1:0]; // [R5]
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_comb begin
    dat_next = 32'h0000_0000;
    case (rd_sel)
      REG_CTRL: begin
        dat_next[`CTRL_MASK_BIT] = mask_reg;
      end
      REG_ASSIGN_SLP: begin
        dat_next[`NUM_RES-1:0] = assign_slp_reg;
      end
      REG_ASSIGN_A: begin
        dat_next[`NUM_RES-1:0] = assign_a_reg;
      end
      REG_ASSIGN_B: begin
        dat_next[`NUM_RES-1:0] = assign_b_reg;
      end
      REG_STATUS: begin
        dat_next[`ST_MODE_LSB +: `NUM_RES] = mode_w;
        dat_next[`ST_STATE_LSB +: 2]      = sq.state;
        dat_next[`ST_PIN_SLP_BIT]         = sleep_request_pin_n_i;
        dat_next[`ST_PIN_A_BIT]           = direct_mode_pin_a_i;
        dat_next[`ST_PIN_B_BIT]           = direct_mode_pin_b_i;
      end
      default: begin
        dat_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      dat_reg <= dat_next;
    end
  end

  assign dat_o = dat_reg;

  // ----------------------------------------------------------------------
  // Sleep request towards the sequencer
  // ----------------------------------------------------------------------
  // Low pin level is a request; the mask freezes the sequencer's decision.
  assign sq.sleep_req = ~sleep_request_pin_n_i; // [R1]
  assign sq.hold      = mask_reg;               // [R7]

  sleep_sequencer u_seq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sq    (sq.seq)
  );

  // ----------------------------------------------------------------------
  // Resource modes
  // ----------------------------------------------------------------------
  resource_mode_mux u_mux (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .assign_slp_i (assign_slp_reg),
    .assign_a_i   (assign_a_reg),
    .assign_b_i   (assign_b_reg),
    .pin_a_i      (direct_mode_pin_a_i),
    .pin_b_i      (direct_mode_pin_b_i),
    .seq_awake_i  (sq.awake),
    .mode_o       (mode_w)
  );

  assign resource_mode_o = mode_w;
  assign seq_busy_o      = (sq.state == SEQ_TO_SLEEP) || (sq.state == SEQ_TO_ACTIVE);

endmodule // resource_sleep_active_control

// file: tb/host_pin_model.sv
// Host side model: drives the sleep request and direct mode pins
// Assumes the bench sets the wanted levels just after a rising edge
`timescale 1ns/1ns
module host_pin_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sleep_set_i,
  input  wire logic a_set_i,
  input  wire logic b_set_i,
  output logic      sleep_request_pin_n_o,
  output logic      direct_mode_pin_a_o,
  output logic      direct_mode_pin_b_o
);
  // --------------------------------------------------------------------
  // Pin drivers, registered like a host GPIO
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_request_pin_n_o <= 1'b1;
      direct_mode_pin_a_o   <= 1'b1;
      direct_mode_pin_b_o   <= 1'b1;
    end else begin
      sleep_request_pin_n_o <= ~sleep_set_i;
      direct_mode_pin_a_o   <= a_set_i;
      direct_mode_pin_b_o   <= b_set_i;
    end
  end
endmodule // host_pin_model

// file: tb/rsac_checker.sv
// Port checker of the sleep/active control block
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`include "rsac_cfg.svh"
module rsac_checker
  import rsac_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        sleep_request_pin_n_i,
  input wire logic        direct_mode_pin_a_i,
  input wire logic        direct_mode_pin_b_i,
  input wire res_vec_t    resource_mode_o,
  input wire logic        seq_busy_o
);
  logic [9:0] busy_cnt_reg;
  logic       asleep_reg;
  logic       rst_q_reg;
  localparam logic [9:0] SEQ_LEN = 10'(`NUM_RES * `SEQ_STEP_CYC);
  default clocking cb @(posedge clk_i); endclocking
  // Reset also seen one edge late, so the release edge is never checked
  default disable iff (rst_i || rst_q_reg);
  always_ff @(posedge clk_i) begin
    rst_q_reg <= rst_i;
  end
  // --------------------------------------------------------------------
  // Helper counter, asleep flag and sequences
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !seq_busy_o) busy_cnt_reg <= 10'h000;
    else busy_cnt_reg <= busy_cnt_reg + 10'h001;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) asleep_reg <= 1'b0;
    else if ($fell(seq_busy_o)) asleep_reg <= ~asleep_reg;
  end
  sequence bus_req; cyc_i && stb_i && !ack_o; endsequence
  sequence ack_pulse; ack_o ##1 !ack_o; endsequence
  sequence sleep_start;
    !seq_busy_o && !$past(sleep_request_pin_n_i) ##1 seq_busy_o;
  endsequence
  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  chk_req_gets_ack: assert property (bus_req |=> ack_pulse)
    else $error("request not answered by one ack pulse");
  chk_no_idle_ack: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  chk_rdata_hold: assert property ($changed(dat_o) |-> ack_o && !we_i)
    else $error("read data changed outside a read");
  chk_seq_start_level: assert property (
    $rose(seq_busy_o) |-> $past(sleep_request_pin_n_i) == asleep_reg)
    else $error("sequence started against pin level");
  chk_seq_min_len: assert property ($rose(seq_busy_o) |-> seq_busy_o[*8])
    else $error("sequence too short");
  chk_seq_total_len: assert property (
    $fell(seq_busy_o) |-> busy_cnt_reg == SEQ_LEN)
    else $error("sequence length wrong");
  chk_modes_still: assert property (
    $stable(direct_mode_pin_a_i) && $stable(direct_mode_pin_b_i) && !$past(ack_o)
    && !seq_busy_o && !$past(seq_busy_o) && !$past(seq_busy_o, 2)
    && !$past(seq_busy_o, 3) |=> $stable(resource_mode_o))
    else $error("modes changed without cause");
  chk_busy_no_early: assert property (sleep_start |-> $past(asleep_reg) == 1'b0)
    else $error("sleep sequence started while asleep");
endmodule // rsac_checker

// file: tb/resource_sleep_active_control_tb_top.sv
// Bench of the sleep/active control block: Wishbone tasks and pin scenarios
// Assumes the host pin model and the port checker
`timescale 1ns/1ns
`include "rsac_cfg.svh"
module resource_sleep_active_control_tb_top;
  import rsac_pkg::*;
  logic              clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, seq_busy_o;
  logic [`ADR_W-1:0] adr_i;
  logic [31:0]       dat_i, dat_o, q;
  logic [3:0]        sel_i;
  logic              sleep_request_pin_n_i, direct_mode_pin_a_i, direct_mode_pin_b_i;
  logic              slp_req, pin_a, pin_b;
  res_vec_t          resource_mode_o;
  int                errors, cmp_count;
  logic [7:0]        exp_m [4] = '{8'h0F, 8'h00, 8'hF0, 8'hFF};
  logic [3:0]        tab_a = 4'h9;
  logic [3:0]        tab_b = 4'hC;
  resource_sleep_active_control i_resource_sleep_active_control (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o, .sleep_request_pin_n_i,
    .direct_mode_pin_a_i, .direct_mode_pin_b_i, .resource_mode_o, .seq_busy_o);
  host_pin_model i_host_pin_model (.clk_i, .rst_i, .sleep_set_i(slp_req), .a_set_i(pin_a),
    .b_set_i(pin_b), .sleep_request_pin_n_o(sleep_request_pin_n_i),
    .direct_mode_pin_a_o(direct_mode_pin_a_i), .direct_mode_pin_b_o(direct_mode_pin_b_i));
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task end_of_test;
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {1'b1, 1'b1, w, a, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task rd(input logic [7:0] a, input string n, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(n, e, q);
  endtask
  task wait_busy(input logic v, input int b);
    int n;
    n = 0;
    while (seq_busy_o !== v && n < b) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= b) begin
      errors++;
      end_of_test();
    end
  endtask
  // --------------------------------------------------------------------
  // Clock and scenarios
  // --------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {1'b1, 47'h0};
    {slp_req, pin_a, pin_b, errors, cmp_count} = {3'b011, 64'h0};
    tick(10);
    rst_i <= 1'b0;
    chk("mode_rst", 32'hFF, resource_mode_o);
    rd(8'h00, "ctrl_rst", 32'h1);
    for (int i = 4; i <= 12; i += 4) rd(8'(i), "assign_rst", 32'h0);
    rd(8'h14, "unmapped", 32'h0);
    slp_req <= 1'b1;
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    tick(10);
    chk("busy_masked", 32'h0, seq_busy_o);
    chk("mode_free", 32'hFF, resource_mode_o);
    wb(1'b1, 8'h08, 32'h0F, 4'hF);
    wb(1'b1, 8'h0C, 32'hF0, 4'hF);
    wb(1'b1, 8'h08, 32'hFF, 4'h0);
    rd(8'h08, "assign_a", 32'h0F);
    for (int i = 0; i < 4; i++) begin
      pin_a <= tab_a[i];
      pin_b <= tab_b[i];
      tick(3);
      chk("mode_direct", exp_m[i], resource_mode_o);
    end
    wb(1'b1, 8'h0C, 32'h00, 4'hF);
    wb(1'b1, 8'h08, 32'h02, 4'hF);
    wb(1'b1, 8'h04, 32'h81, 4'hF);
    wb(1'b1, 8'h00, 32'h0, 4'h1);
    wait_busy(1'b1, 20);
    rd(8'h10, "status_to_sleep", 32'h0601_00FF);
    tick(150);
    chk("mode_step0", 32'hFE, resource_mode_o);
    pin_a <= 1'b0;
    tick(3);
    chk("mode_bypass", 32'hFC, resource_mode_o);
    wait_busy(1'b0, 1000);
    tick(2);
    rd(8'h10, "status_asleep", 32'h0402_007C);
    wb(1'b1, 8'h00, 32'h1, 4'h1);
    slp_req <= 1'b0;
    tick(10);
    chk("busy_masked_wake", 32'h0, seq_busy_o);
    chk("mode_masked_wake", 32'h7C, resource_mode_o);
    wb(1'b1, 8'h00, 32'h0, 4'h1);
    wait_busy(1'b1, 20);
    pin_a <= 1'b1;
    tick(150);
    chk("mode_wake7", 32'hFE, resource_mode_o);
    wait_busy(1'b0, 1000);
    tick(2);
    rd(8'h10, "status_awake", 32'h0700_00FF);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    rd(8'h00, "ctrl_rerst", 32'h1);
    end_of_test();
  end
endmodule // resource_sleep_active_control_tb_top
bind resource_sleep_active_control rsac_checker i_rsac_checker (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .dat_o, .ack_o, .sleep_request_pin_n_i, .direct_mode_pin_a_i,
  .direct_mode_pin_b_i, .resource_mode_o, .seq_busy_o);
